// [hdl/freq_program_control_defs.vh]
/*
  Constants of the frequency program control register bank: byte offsets,
  field positions, reset values and serial-port figures.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef FREQ_PROGRAM_CONTROL_DEFS_VH
`define FREQ_PROGRAM_CONTROL_DEFS_VH

// register byte offsets (command codes on the serial port)
`define OFS_CPU_MULT_MSB_AND_DIVIDER 8'h0F
`define OFS_SERIAL_REF_MULT_LOW 8'h10
`define OFS_WATCHDOG_RESTORE_MULT_LOW 8'h11
`define OFS_FREQUENCY_MODE_CONTROL 8'h12
`define REG_COUNT 4
`define REG_RESET 8'h00

// cpu_mult_msb_and_divider fields
`define DIV_MSB 6
`define CPU_MULT_MSB_BIT 7

// frequency_mode_control fields
`define SERIAL_REF_MSB_BIT 7
`define SOFT_OVERRIDE_BIT 6
`define STEP_ENABLE_BIT 5
`define RESET_INPUT_EN_BIT 4
`define SERIAL_REF_PROG_BIT 3
`define CPU_PROG_BIT 2
`define AUTO_RESTORE_BIT 1
`define RESTORE_MSB_BIT 0

// widths
`define MULT_W 9
`define DIV_W 7
`define STRAP_W 5
`define INDEX_W 4

// serial port
`define SLAVE_ADDR 7'h35
`define READ_UNMAPPED 8'hFF
`define BIT_COUNT_FULL 4'h8

// restore hold codes
`define HOLD_NONE 2'h0
`define HOLD_HW 2'h1
`define HOLD_MULT 2'h2

`endif

// [hdl/freq_program_control_regs.v]
/*
  Control register bytes 15 to 18 of a clock generator behind its SMBus
  byte port, and the multiplier, divider, ratio and enables they select.
  Assumes: scl/sda pins asynchronous to mclk; step multipliers, table index,
  restore source and reboot pulse on mclk; sda resolved outside (pull-up).
*/
// Summary of operation
// - byte 15 holds divider and multiplier msb
// - programmed enable uses programmed multiplier and divider
// - override clear: ratio from latched strap select
// - override set: ratio from soft table index
// - byte 16 holds serial-reference multiplier low bits
// - byte 18 bit 7 is serial-reference msb
// - restore multiplier in byte 17 plus byte 18 bit 0
// - byte 18 bit 6 chooses strap or table
// - byte 18 bit 5 enables pin-stepped frequency
// - byte 18 bit 4 enables reset input
// - byte 18 bit 3 enables serial-reference programming
// - byte 18 bit 2 enables programmed CPU frequency
// - byte 18 bit 1 picks auto or manual restore
// - all bits read/write, reset to zero
// - step pins pick original or step multiplier
// - restore source picks strap or restore multiplier
`timescale 1ns/1ps
`include "freq_program_control_defs.vh"
module freq_program_control_regs #(
  parameter [6:0] SLAVE_ADDR = `SLAVE_ADDR,
  parameter MULT_W = `MULT_W
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // serial side-band port
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // pins and settings from the rest of the device
  input wire [`STRAP_W-1:0] strap_freq_select,
  input wire [1:0] step_select_pins,
  input wire [`INDEX_W-1:0] soft_freq_table_index,
  input wire [MULT_W-1:0] step_multiplier_one,
  input wire [MULT_W-1:0] step_multiplier_two,
  input wire [MULT_W-1:0] step_multiplier_three,
  input wire restore_source,
  input wire wd_reboot,
  // to the frequency controller
  output wire [MULT_W-1:0] cpu_mult_active,
  output wire [`DIV_W-1:0] cpu_div_active,
  output wire cpu_prog_active,
  output wire ratio_from_table,
  output wire [`STRAP_W-1:0] ratio_code,
  output wire freq_from_table,
  output wire step_active,
  output wire [MULT_W-1:0] serial_ref_multiplier,
  output wire serial_ref_prog_active,
  output wire reset_input_enable,
  output wire auto_restore_mode,
  output wire [MULT_W-1:0] restore_multiplier
);
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_ACK_A = 9'h004;
  localparam [8:0] ST_CMD = 9'h008;
  localparam [8:0] ST_ACK_C = 9'h010;
  localparam [8:0] ST_WDATA = 9'h020;
  localparam [8:0] ST_ACK_W = 9'h040;
  localparam [8:0] ST_RDATA = 9'h080;
  localparam [8:0] ST_RACK = 9'h100;
  // synchronisers
  reg scl_m_reg, scl_s_reg, scl_d_reg;
  reg sda_m_reg, sda_s_reg, sda_d_reg;
  reg [1:0] step_m_reg, step_s_reg;
  reg [`STRAP_W-1:0] strap_m_reg, strap_s_reg, strap_latched_reg;
  reg [1:0] strap_wait_reg;

  // serial engine
  reg [8:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg, cmd_reg;
  reg rack_ok_reg, sda_oe_reg, sda_out_reg, wr_pulse_reg;

  // register storage
  reg [7:0] bank_reg [0:`REG_COUNT-1];
  reg [1:0] hold_reg;

  // output registers
  reg [MULT_W-1:0] cpu_mult_reg, serial_mult_reg, restore_mult_reg;
  reg [`DIV_W-1:0] cpu_div_reg;
  reg [`STRAP_W-1:0] ratio_code_reg;
  reg cpu_prog_reg, ratio_table_reg, freq_table_reg, step_active_reg;
  reg serial_prog_reg, reset_in_en_reg, auto_restore_reg;

  wire scl_rise = scl_s_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s_reg & scl_d_reg;
  wire start_cond = scl_s_reg & scl_d_reg & ~sda_s_reg & sda_d_reg;
  wire stop_cond = scl_s_reg & scl_d_reg & sda_s_reg & ~sda_d_reg;
  wire byte_done = (bit_cnt_reg == `BIT_COUNT_FULL);
  wire cmd_mapped = (cmd_reg >= `OFS_CPU_MULT_MSB_AND_DIVIDER) && (cmd_reg <= `OFS_FREQUENCY_MODE_CONTROL);
  wire [7:0] cmd_index = cmd_reg - `OFS_CPU_MULT_MSB_AND_DIVIDER;
  wire [1:0] reg_sel = cmd_index[1:0];
  wire [7:0] next_cmd = cmd_reg + 8'h01;
  wire [7:0] next_index = next_cmd - `OFS_CPU_MULT_MSB_AND_DIVIDER;
  wire next_mapped = (next_cmd >= `OFS_CPU_MULT_MSB_AND_DIVIDER) && (next_cmd <= `OFS_FREQUENCY_MODE_CONTROL);
  wire [7:0] rd_now = cmd_mapped ? bank_reg[reg_sel] : `READ_UNMAPPED;
  wire [7:0] rd_next = next_mapped ? bank_reg[next_index[1:0]] : `READ_UNMAPPED;

  // field views
  wire [7:0] byte15 = bank_reg[0];
  wire [7:0] byte16 = bank_reg[1];
  wire [7:0] byte17 = bank_reg[2];
  wire [7:0] byte18 = bank_reg[3];
  wire [MULT_W-1:0] cpu_feedback_multiplier = {byte15[`CPU_MULT_MSB_BIT], 8'h00};
  wire [`DIV_W-1:0] cpu_reference_divider = byte15[`DIV_MSB:0];
  wire serial_ref_multiplier_msb = byte18[`SERIAL_REF_MSB_BIT];
  wire [MULT_W-1:0] serial_ref_mult_field = {serial_ref_multiplier_msb, byte16};
  wire [MULT_W-1:0] restore_mult_field = {byte18[`RESTORE_MSB_BIT], byte17};
  wire soft_select_override = byte18[`SOFT_OVERRIDE_BIT];
  wire pin_stepped_freq_enable = byte18[`STEP_ENABLE_BIT];
  wire cpu_prog_en = byte18[`CPU_PROG_BIT];

  // pin synchronisers and strap latch
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      step_m_reg <= 2'h0;
      step_s_reg <= 2'h0;
      strap_m_reg <= 5'h00;
      strap_s_reg <= 5'h00;
      strap_latched_reg <= 5'h00;
      strap_wait_reg <= 2'h0;
    end else begin
      scl_m_reg <= scl_in;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= sda_in;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
      step_m_reg <= step_select_pins;
      step_s_reg <= step_m_reg;
      strap_m_reg <= strap_freq_select;
      strap_s_reg <= strap_m_reg;
      // straps caught once the synchroniser holds pin values
      if (strap_wait_reg != 2'h3) begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
      if (strap_wait_reg == 2'h2) begin
        strap_latched_reg <= strap_s_reg;
      end
    end
  end

  // serial byte engine
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      rack_ok_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
    end else begin
      wr_pulse_reg <= 1'b0;
      if (start_cond) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe_reg <= 1'b0;
          end
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise && !byte_done) begin
              shift_reg <= {shift_reg[6:0], sda_s_reg};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && byte_done) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == SLAVE_ADDR) begin
                  rack_ok_reg <= shift_reg[0];
                  sda_oe_reg <= 1'b1;
                  state_reg <= ST_ACK_A;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else if (state_reg == ST_CMD) begin
                cmd_reg <= shift_reg;
                sda_oe_reg <= 1'b1;
                state_reg <= ST_ACK_C;
              end else begin
                wr_pulse_reg <= cmd_mapped;
                sda_oe_reg <= 1'b1;
                state_reg <= ST_ACK_W;
              end
            end
          end
          ST_ACK_A: begin
            if (scl_fall) begin
              if (rack_ok_reg) begin
                shift_reg <= rd_now;
                sda_oe_reg <= ~rd_now[7];
                state_reg <= ST_RDATA;
              end else begin
                sda_oe_reg <= 1'b0;
                state_reg <= ST_CMD;
              end
            end
          end
          ST_ACK_C: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_WDATA;
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              cmd_reg <= next_cmd;
              state_reg <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (byte_done) begin
                sda_oe_reg <= 1'b0;
                state_reg <= ST_RACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_oe_reg <= ~shift_reg[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              rack_ok_reg <= ~sda_s_reg;
            end else if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (rack_ok_reg) begin
                cmd_reg <= next_cmd;
                shift_reg <= rd_next;
                sda_oe_reg <= ~rd_next[7];
                state_reg <= ST_RDATA;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // register bytes, one per entry
  genvar gi;
  generate
    for (gi = 0; gi < `REG_COUNT; gi = gi + 1) begin : g_bank
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          bank_reg[gi] <= `REG_RESET;
        end else if (wr_pulse_reg && reg_sel == gi) begin
          bank_reg[gi] <= shift_reg;
        end
      end
    end
  endgenerate

  // watchdog reboot hold, released by the next register write
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_reg <= `HOLD_NONE;
    end else if (wd_reboot) begin
      hold_reg <= restore_source ? `HOLD_MULT : `HOLD_HW;
    end else if (wr_pulse_reg) begin
      hold_reg <= `HOLD_NONE;
    end
  end

  // frequency controller outputs, recomputed every cycle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpu_mult_reg <= 9'h000;
      cpu_div_reg <= 7'h00;
      cpu_prog_reg <= 1'b0;
      ratio_table_reg <= 1'b0;
      ratio_code_reg <= 5'h00;
      freq_table_reg <= 1'b0;
      step_active_reg <= 1'b0;
      serial_mult_reg <= 9'h000;
      serial_prog_reg <= 1'b0;
      reset_in_en_reg <= 1'b0;
      auto_restore_reg <= 1'b0;
      restore_mult_reg <= 9'h000;
    end else begin
      freq_table_reg <= soft_select_override & (hold_reg != `HOLD_HW);
      reset_in_en_reg <= byte18[`RESET_INPUT_EN_BIT];
      auto_restore_reg <= byte18[`AUTO_RESTORE_BIT];
      serial_prog_reg <= byte18[`SERIAL_REF_PROG_BIT];
      serial_mult_reg <= serial_ref_mult_field;
      restore_mult_reg <= restore_mult_field;
      cpu_div_reg <= cpu_reference_divider;
      if (soft_select_override && hold_reg != `HOLD_HW) begin
        ratio_table_reg <= 1'b1;
        ratio_code_reg <= {1'b0, soft_freq_table_index};
      end else begin
        ratio_table_reg <= 1'b0;
        ratio_code_reg <= strap_latched_reg;
      end
      step_active_reg <= 1'b0;
      if (hold_reg == `HOLD_HW) begin
        cpu_prog_reg <= 1'b0;
        cpu_mult_reg <= 9'h000;
      end else if (hold_reg == `HOLD_MULT) begin
        cpu_prog_reg <= 1'b1;
        cpu_mult_reg <= restore_mult_field;
      end else if (pin_stepped_freq_enable && step_s_reg != 2'h0) begin
        step_active_reg <= 1'b1;
        cpu_prog_reg <= 1'b1;
        case (step_s_reg)
          2'h1: cpu_mult_reg <= step_multiplier_one;
          2'h2: cpu_mult_reg <= step_multiplier_two;
          default: cpu_mult_reg <= step_multiplier_three;
        endcase
      end else if (cpu_prog_en) begin
        cpu_prog_reg <= 1'b1;
        cpu_mult_reg <= cpu_feedback_multiplier;
      end else begin
        cpu_prog_reg <= 1'b0;
        cpu_mult_reg <= 9'h000;
      end
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe = sda_oe_reg;
  assign cpu_mult_active = cpu_mult_reg;
  assign cpu_div_active = cpu_div_reg;
  assign cpu_prog_active = cpu_prog_reg;
  assign ratio_from_table = ratio_table_reg;
  assign ratio_code = ratio_code_reg;
  assign freq_from_table = freq_table_reg;
  assign step_active = step_active_reg;
  assign serial_ref_multiplier = serial_mult_reg;
  assign serial_ref_prog_active = serial_prog_reg;
  assign reset_input_enable = reset_in_en_reg;
  assign auto_restore_mode = auto_restore_reg;
  assign restore_multiplier = restore_mult_reg;

endmodule

// [testbench/freq_program_control_regs_assertions.sv]
/*
  Checker for the frequency program control register bank outputs.
  Assumes a bind from the bench top file; one clock mclk, async reset rst.
*/
`timescale 1ns/1ps
`include "freq_program_control_defs.vh"
module freq_program_control_regs_assertions #(
  parameter MULT_W = 9
) (
  // clock, reset and serial port
  input wire mclk,
  input wire rst,
  input wire scl_in,
  input wire sda_oe,
  // watchdog and table inputs
  input wire [`INDEX_W-1:0] soft_freq_table_index,
  input wire restore_source,
  input wire wd_reboot,
  // controller outputs
  input wire [MULT_W-1:0] cpu_mult_active,
  input wire cpu_prog_active,
  input wire ratio_from_table,
  input wire [`STRAP_W-1:0] ratio_code,
  input wire freq_from_table,
  input wire step_active,
  input wire [MULT_W-1:0] restore_multiplier
);
  reg [2:0] up_cnt;
  // cycles since reset release, saturating
  always @(posedge mclk or posedge rst) begin
    if (rst) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_table_ratio;
    ratio_from_table && $past(ratio_from_table) |-> ratio_code == {1'b0, $past(soft_freq_table_index)};
  endproperty
  a_table_ratio: assert property (p_table_ratio) else $error("table ratio code wrong");
  property p_strap_stable;
    !ratio_from_table && !$past(ratio_from_table) && up_cnt == 3'h7 |-> $stable(ratio_code);
  endproperty
  a_strap_stable: assert property (p_strap_stable) else $error("strap ratio moved");
  property p_idle_mult;
    !cpu_prog_active |-> cpu_mult_active == {MULT_W{1'b0}};
  endproperty
  a_idle_mult: assert property (p_idle_mult) else $error("multiplier without source");
  property p_step_prog;
    step_active |-> cpu_prog_active;
  endproperty
  a_step_prog: assert property (p_step_prog) else $error("step without prog flag");
  property p_table_flag;
    ratio_from_table == freq_from_table;
  endproperty
  a_table_flag: assert property (p_table_flag) else $error("ratio source differs");
  property p_ack_scl_low;
    sda_oe != $past(sda_oe) && up_cnt == 3'h7 |-> !scl_in;
  endproperty
  a_ack_scl_low: assert property (p_ack_scl_low) else $error("data moved with clock high");
  property p_hw_restore;
    wd_reboot && !restore_source |-> ##2 (!cpu_prog_active && !ratio_from_table);
  endproperty
  a_hw_restore: assert property (p_hw_restore) else $error("strap restore not applied");
  property p_restore_mult;
    wd_reboot && restore_source |-> ##2 (cpu_prog_active && cpu_mult_active == restore_multiplier);
  endproperty
  a_restore_mult: assert property (p_restore_mult) else $error("restore multiplier not applied");
  c_step: cover property (step_active);
  c_table: cover property (ratio_from_table);
  c_ack: cover property ($rose(sda_oe));
endmodule

// [testbench/tb.sv]
/*
  Self-checking bench for the frequency program control register bank.
  Assumes the checker is compiled first; the bench bit-bangs the serial port.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks = total_checks + 1; if ((g) !== (e)) begin bad_count = bad_count + 1; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  localparam [6:0] ADDR = 7'h35;
  localparam [8:0] S1 = 9'h101, S2 = 9'h0AA, S3 = 9'h155;
  reg mclk = 0, rst = 1, scl = 1, msda = 1, rsrc = 0, wdr = 0;
  reg [4:0] strap = 5'h15;
  reg [1:0] pins = 2'h0;
  reg [3:0] idx = 4'hA;
  reg [8:0] s1 = S1, s2 = S2, s3 = S3;
  wire sda_oe, sda_out, prog, rft, fft, stp, srp, rie, arm;
  wire [8:0] mult, srm, rm;
  wire [6:0] div;
  wire [4:0] rcode;
  // open-drain wire with pull-up
  wire sda_in = msda & ~sda_oe;
  integer bad_count, total_checks, cyc = 0, i, p;
  reg [31:0] ev;
  reg [7:0] r;
  reg a;
  freq_program_control_regs #(.SLAVE_ADDR(ADDR)) DUT (
    .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_freq_select(strap), .step_select_pins(pins), .soft_freq_table_index(idx),
    .step_multiplier_one(s1), .step_multiplier_two(s2), .step_multiplier_three(s3),
    .restore_source(rsrc), .wd_reboot(wdr), .cpu_mult_active(mult), .cpu_div_active(div),
    .cpu_prog_active(prog), .ratio_from_table(rft), .ratio_code(rcode), .freq_from_table(fft),
    .step_active(stp), .serial_ref_multiplier(srm), .serial_ref_prog_active(srp),
    .reset_input_enable(rie), .auto_restore_mode(arm), .restore_multiplier(rm)
  );
  always #20 mclk = ~mclk;
  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  task clk_bit(input b, output v);
    begin
      @(posedge mclk) msda <= b;
      repeat (4) @(posedge mclk);
      scl <= 1;
      repeat (3) @(posedge mclk);
      @(negedge mclk) v = sda_in;
      repeat (3) @(posedge mclk);
      scl <= 0;
      repeat (2) @(posedge mclk);
    end
  endtask
  task start;
    begin
      @(posedge mclk) msda <= 1;
      repeat (4) @(posedge mclk);
      scl <= 1;
      repeat (5) @(posedge mclk);
      msda <= 0;
      repeat (5) @(posedge mclk);
      scl <= 0;
    end
  endtask
  task stop;
    begin
      @(posedge mclk) msda <= 0;
      repeat (4) @(posedge mclk);
      scl <= 1;
      repeat (5) @(posedge mclk);
      msda <= 1;
      repeat (6) @(posedge mclk);
    end
  endtask
  // eight bits out or in, then the acknowledge bit
  task xbyte(input [7:0] w, input last, output [7:0] v, output ack);
    integer k;
    reg b;
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        clk_bit(w[k], b);
        v[k] = b;
      end
      clk_bit(last, b);
      ack = ~b;
    end
  endtask
  task reg_wr(input [7:0] c, input [31:0] d, input integer n);
    integer k;
    reg ok, ak;
    begin
      start;
      xbyte({ADDR, 1'b0}, 1'b1, r, ok);
      xbyte(c, 1'b1, r, ak);
      ok = ok & ak;
      for (k = 0; k < n; k = k + 1) begin
        xbyte(d[31 - 8 * k -: 8], 1'b1, r, ak);
        ok = ok & ak;
      end
      stop;
      `CHK(ok, 1'b1)
    end
  endtask
  task rchk(input [7:0] c, input [7:0] e);
    begin
      start;
      xbyte({ADDR, 1'b0}, 1'b1, r, a);
      xbyte(c, 1'b1, r, a);
      start;
      xbyte({ADDR, 1'b1}, 1'b1, r, a);
      xbyte(8'hFF, 1'b1, r, a);
      stop;
      `CHK(r, e)
    end
  endtask
  task pulse_reboot;
    begin
      @(posedge mclk) wdr <= 1;
      @(posedge mclk) wdr <= 0;
      repeat (3) @(posedge mclk);
    end
  endtask
  initial begin
    bad_count = 0;
    total_checks = 0;
    repeat (2) @(posedge mclk);
    rst <= 0;
    repeat (6) @(posedge mclk);
    for (i = 15; i < 19; i = i + 1) rchk(i[7:0], 8'h00);
    `CHK({sda_out, prog, stp, srp, rie, arm, fft, rft, srm, rm, div}, 33'h0)
    `CHK(rcode, 5'h15)
    $display("test reset values done");
    reg_wr(8'h0F, 32'hA53C9681, 4);
    for (i = 15; i < 19; i = i + 1) begin
      ev = 32'hA53C9681 >> (8 * (18 - i));
      rchk(i[7:0], ev[7:0]);
    end
    `CHK(div, 7'h25)
    `CHK(srm, 9'h13C)
    `CHK(rm, 9'h196)
    $display("test field mapping done");
    for (i = 1; i < 7; i = i + 1) begin
      reg_wr(8'h12, 32'h1 << (24 + i), 1);
      ev = ((32'h1 << i) >> 1) & ~32'h10;
      `CHK({fft, stp, rie, srp, prog, arm}, ev[5:0])
      `CHK(rft, i == 6)
    end
    $display("test control bits done");
    reg_wr(8'h12, 32'h44000000, 1);
    `CHK({prog, mult[8], rft, rcode}, {3'b111, 5'h0A})
    reg_wr(8'h12, 32'h04000000, 1);
    `CHK({prog, rft, rcode}, {2'b10, 5'h15})
    $display("test ratio source done");
    reg_wr(8'h12, 32'h24000000, 1);
    for (p = 0; p < 4; p = p + 1) begin
      @(posedge mclk) pins <= p[1:0];
      repeat (6) @(posedge mclk);
      if (p == 0) `CHK({stp, prog}, 2'b01)
      else `CHK({stp, mult}, {1'b1, (p == 1) ? S1 : (p == 2) ? S2 : S3})
    end
    reg_wr(8'h12, 32'h04000000, 1);
    `CHK(stp, 1'b0)
    @(posedge mclk) pins <= 2'h0;
    $display("test step pins done");
    @(posedge mclk) rsrc <= 1;
    pulse_reboot;
    `CHK({prog, mult}, {1'b1, 9'h096})
    reg_wr(8'h12, 32'h44000000, 1);
    @(posedge mclk) rsrc <= 0;
    pulse_reboot;
    `CHK({prog, fft, rft, rcode}, {3'b000, 5'h15})
    reg_wr(8'h12, 32'h04000000, 1);
    `CHK(prog, 1'b1)
    $display("test watchdog restore done");
    rchk(8'h13, 8'hFF);
    start;
    xbyte({7'h36, 1'b0}, 1'b1, r, a);
    stop;
    `CHK(a, 1'b0)
    @(posedge mclk) rst <= 1;
    repeat (2) @(posedge mclk);
    rst <= 0;
    repeat (6) @(posedge mclk);
    rchk(8'h12, 8'h00);
    `CHK(rcode, 5'h15)
    $display("test refusals and reset done");
    test_done;
  end
endmodule
bind freq_program_control_regs freq_program_control_regs_assertions #(.MULT_W(MULT_W)) u_chk (
  .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_oe(sda_oe), .soft_freq_table_index(soft_freq_table_index),
  .restore_source(restore_source), .wd_reboot(wd_reboot), .cpu_mult_active(cpu_mult_active),
  .cpu_prog_active(cpu_prog_active), .ratio_from_table(ratio_from_table), .ratio_code(ratio_code),
  .freq_from_table(freq_from_table), .step_active(step_active), .restore_multiplier(restore_multiplier)
);
